// ==== acr_cfg.svh ====
/*
 * Holds: register offsets, field positions, reset values and timing
 * counts of the ADC option and calibration coefficient register slice.
 * Assumes: included by bare name; the clock runs at 25 MHz.
 */
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

// ==========================================================================
// register offsets (device side)
`define ACR_OFS_OPTION 4'h0
`define ACR_OFS_GAIN_COEFF_BYTE0 4'h8
`define ACR_OFS_GAIN_COEFF_BYTE1 4'h9
`define ACR_OFS_GAIN_COEFF_BYTE2 4'hA
`define ACR_OFS_OFFS0 4'hB
`define ACR_OFS_OFFS1 4'hC
`define ACR_OFS_OFFS2 4'hD

// ==========================================================================
// field positions and codes
`define ACR_OPT_PD_BIT 0
`define ACR_OPT_ID_LSB 1
`define ACR_MODE_IDLE 4'h0
`define ACR_GAIN_W 18
`define ACR_OFFS_W 20

// ==========================================================================
// reset values
`define ACR_RST_GAIN 18'h00001
`define ACR_RST_OFFS 20'h00000
`define ACR_RST_PD 1'b0

// ==========================================================================
// host command registers
`define ACR_H_ADDR 3'h0
`define ACR_H_DATA 3'h1
`define ACR_H_CTRL 3'h2
`define ACR_H_STAT 3'h3
`define ACR_H_RDAT 3'h4
`define ACR_H_GO_WR 0
`define ACR_H_GO_RD 1

// ==========================================================================
// timing: least times round up to whole cycles
`define ACR_CLK_MHZ 25
`define ACR_T_PWRUP_NS 30000
`define ACR_T_WARM_NS 70000
`define ACR_CYC(ns) ((((ns) * `ACR_CLK_MHZ) + 999) / 1000)

`endif

// ==== acr_pkg.sv ====
/*
 * Holds: shared types of the option and calibration register slice.
 * Assumes: compiled before the interface and both ends.
 */
package acr_pkg;
  // ==========================================================================
  // widths
  typedef logic [3:0] acr_addr_t;
  typedef logic [7:0] acr_byte_t;
  typedef logic [10:0] acr_cnt_t;
  typedef logic [2:0] acr_haddr_t;

  // ==========================================================================
  // host sequencer states
  typedef enum logic [3:0] {
    ACR_H_IDLE = 4'b0001,
    ACR_H_HOLD = 4'b0010,
    ACR_H_STRB = 4'b0100,
    ACR_H_CAPT = 4'b1000
  } acr_hstate_e;
endpackage

// ==== acr_if.sv ====
/*
 * Holds: the register port between the host and the converter's slice.
 * Assumes: both ends run on the same clock; read data stand the cycle
 * after the read strobe.
 */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// register port
interface acr_if;
  import acr_pkg::*;
  acr_addr_t addr;
  acr_byte_t wdata;
  logic wr;
  logic rd;
  acr_byte_t rdata;

  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

`default_nettype wire

// ==== acr_dev.sv ====
/*
 * Holds: the converter's option register, gain and offset coefficient
 * registers, and the power-up and analog start-up waits.
 * Assumes: the converter core supplies the conversion mode and the
 * calibration results on the same clock; the host keeps its own waits.
 */
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "acr_cfg.svh"

module acr_dev #(
  parameter logic [6:0] PART_ID = 7'h2B, // arbitrary identifier value
  parameter int PWRUP_CYC = `ACR_CYC(`ACR_T_PWRUP_NS),
  parameter int WARM_CYC = `ACR_CYC(`ACR_T_WARM_NS)
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  acr_if.dev bus,
  input wire logic [3:0] mode_i,
  input wire logic cal_gain_vld_i,
  input wire logic [`ACR_GAIN_W-1:0] cal_gain_i,
  input wire logic cal_offs_vld_i,
  input wire logic [`ACR_OFFS_W-1:0] cal_offs_i,
  output logic [`ACR_GAIN_W-1:0] gain_o,
  output logic [23:0] offset_o,
  output logic analog_pd_o,
  output logic analog_ready_o,
  output logic op_ready_o,
  output logic conv_allow_o
);
  import acr_pkg::*;

  // ==========================================================================
  // state
  // software-visible registers
  logic pd_r;
  logic [`ACR_GAIN_W-1:0] gain_r;
  logic [`ACR_OFFS_W-1:0] offs_r;
  acr_byte_t rdata_r;
  // wait timers and analog state
  acr_cnt_t pwrup_cnt_r;
  logic op_ready_r;
  acr_cnt_t warm_cnt_r;
  logic apd_r;
  logic apd_prev_r;
  // combinational helpers
  logic coeff_wr_ok;
  logic [23:0] offs_ext;
  acr_byte_t rd_nxt;

  // ==========================================================================
  // power-up wait after reset release
  // the counter freezes once ready, so a long run never wraps it
  // and ready never drops again until the next reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pwrup_cnt_r <= '0;
      op_ready_r <= 1'b0;
    end else if (!op_ready_r) begin
      if (pwrup_cnt_r == acr_cnt_t'(PWRUP_CYC - 1)) begin
        op_ready_r <= 1'b1;
      end
      pwrup_cnt_r <= pwrup_cnt_r + 11'h001;
    end
  end

  // ==========================================================================
  // idle power-down bit, written through the option register
  // only bit 0 is stored: the identifier is a constant of the part
  // a write here always lands, powered down or not, since it is
  // the only way to bring the analog block back on in idle mode
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pd_r <= `ACR_RST_PD;
    end else if (bus.wr && bus.addr == `ACR_OFS_OPTION) begin
      pd_r <= bus.wdata[`ACR_OPT_PD_BIT]; // identifier bits ignored
    end
  end

  // ==========================================================================
  // analog block state: power-down only takes hold in idle mode
  // registered so that the edge detector below sees a clean step
  // apd_prev_r keeps last cycle's state to find the power-on edge
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      apd_r <= 1'b0;
      apd_prev_r <= 1'b0;
    end else begin
      apd_r <= pd_r && (mode_i == `ACR_MODE_IDLE);
      apd_prev_r <= apd_r;
    end
  end

  // ==========================================================================
  // start-up wait each time the analog block leaves power-down
  // a fresh power-down cancels a wait in progress, so a short
  // off-on pulse still pays the whole start-up time
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      warm_cnt_r <= '0;
    end else if (apd_prev_r && !apd_r) begin
      warm_cnt_r <= acr_cnt_t'(WARM_CYC);
    end else if (apd_r) begin
      warm_cnt_r <= '0;
    end else if (warm_cnt_r != '0) begin
      warm_cnt_r <= warm_cnt_r - 11'h001;
    end
  end

  // conversion is held off until both waits are over
  // ready drops in the cycle of the power-on edge itself, before
  // the counter is loaded, so no one-cycle ready gap appears
  assign analog_pd_o = apd_r;
  assign analog_ready_o = !apd_r && !(apd_prev_r && !apd_r) && (warm_cnt_r == '0);
  assign op_ready_o = op_ready_r;
  assign conv_allow_o = op_ready_r && analog_ready_o;

  // ==========================================================================
  // host coefficient writes need the internal clock running
  // a blocked write is dropped silently; no refusal is reported here
  assign coeff_wr_ok = bus.wr && !pd_r;

  // gain coefficient: calibration result wins over a host write
  // a write to the top byte keeps only two bits, the rest read zero
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      gain_r <= `ACR_RST_GAIN;
    end else if (cal_gain_vld_i) begin
      gain_r <= cal_gain_i;
    end else if (coeff_wr_ok) begin
      unique case (bus.addr)
        `ACR_OFS_GAIN_COEFF_BYTE0: gain_r[7:0] <= bus.wdata;
        `ACR_OFS_GAIN_COEFF_BYTE1: gain_r[15:8] <= bus.wdata;
        `ACR_OFS_GAIN_COEFF_BYTE2: gain_r[17:16] <= bus.wdata[1:0];
        default: ;
      endcase
    end
  end

  // offset coefficient: calibration result wins over a host write
  // only the low nibble of the top byte is stored; the sign copies
  // above it are rebuilt on every read
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      offs_r <= `ACR_RST_OFFS;
    end else if (cal_offs_vld_i) begin
      offs_r <= cal_offs_i;
    end else if (coeff_wr_ok) begin
      unique case (bus.addr)
        `ACR_OFS_OFFS0: offs_r[7:0] <= bus.wdata;
        `ACR_OFS_OFFS1: offs_r[15:8] <= bus.wdata;
        `ACR_OFS_OFFS2: offs_r[19:16] <= bus.wdata[3:0]; // top nibble is sign
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // 24-bit view of the offset with sign copies; gain goes out unpadded at 18 bits
  // the sign copies are wired, not stored, so they never disagree
  assign offs_ext = {{4{offs_r[`ACR_OFFS_W-1]}}, offs_r};
  assign gain_o = gain_r;
  assign offset_o = offs_ext;

  // ==========================================================================
  // read mux; unmapped offsets read zero
  // decoded from the address every cycle, captured only under a read
  always_comb begin
    rd_nxt = 8'h00;
    unique case (bus.addr)
      `ACR_OFS_OPTION: rd_nxt = {PART_ID, pd_r};
      `ACR_OFS_GAIN_COEFF_BYTE0: rd_nxt = gain_r[7:0];
      `ACR_OFS_GAIN_COEFF_BYTE1: rd_nxt = gain_r[15:8];
      `ACR_OFS_GAIN_COEFF_BYTE2: rd_nxt = {6'h00, gain_r[17:16]};
      `ACR_OFS_OFFS0: rd_nxt = offs_ext[7:0];
      `ACR_OFS_OFFS1: rd_nxt = offs_ext[15:8];
      `ACR_OFS_OFFS2: rd_nxt = offs_ext[23:16];
      default: rd_nxt = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the strobe
  // and fall back to zero so a stale byte is never taken twice
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_r <= 8'h00;
    end else if (bus.rd) begin
      rdata_r <= rd_nxt;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // the register port sees the flopped byte only
  assign bus.rdata = rdata_r;
endmodule

`default_nettype wire

// ==== acr_host.sv ====
/*
 * Holds: the host end; software posts one register access at a time,
 * the host holds it off until the waits are over and drops a coefficient write while powered down.
 * Assumes: same clock as the device; software polls the status register.
 */
`timescale 1ns/1ps
`default_nettype none
`include "acr_cfg.svh"

module acr_host #(
  parameter int PWRUP_CYC = `ACR_CYC(`ACR_T_PWRUP_NS),
  parameter int WARM_CYC = `ACR_CYC(`ACR_T_WARM_NS)
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  acr_if.host bus,
  input wire logic [2:0] sw_addr_i,
  input wire logic [7:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [7:0] sw_rdata_o
);
  import acr_pkg::*;

  // ==========================================================================
  // state
  acr_hstate_e st_r;
  acr_addr_t tgt_r;
  acr_byte_t dat_r;
  acr_byte_t rres_r;
  logic is_rd_r;
  logic pd_shadow_r;
  logic refused_r;
  logic wr_r;
  logic rd_r;
  acr_byte_t srd_r;
  acr_cnt_t pwrup_cnt_r;
  acr_cnt_t warm_cnt_r;
  logic go;
  logic coeff_tgt;
  logic clear_pd;
  logic may_go;

  assign go = sw_wr_i && sw_addr_i == `ACR_H_CTRL && st_r == ACR_H_IDLE &&
              (sw_wdata_i[`ACR_H_GO_WR] || sw_wdata_i[`ACR_H_GO_RD]);
  assign coeff_tgt = tgt_r >= `ACR_OFS_GAIN_COEFF_BYTE0 && tgt_r <= `ACR_OFS_OFFS2;
  assign clear_pd = st_r == ACR_H_STRB && !is_rd_r && tgt_r == `ACR_OFS_OPTION &&
                    pd_shadow_r && !dat_r[`ACR_OPT_PD_BIT];
  assign may_go = pwrup_cnt_r == '0 && warm_cnt_r == '0;

  // ==========================================================================
  // waits after reset and after the analog block is switched on
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pwrup_cnt_r <= acr_cnt_t'(PWRUP_CYC);
      warm_cnt_r <= '0;
    end else begin
      if (pwrup_cnt_r != '0) begin
        pwrup_cnt_r <= pwrup_cnt_r - 11'h001;
      end
      if (clear_pd) begin
        warm_cnt_r <= acr_cnt_t'(WARM_CYC);
      end else if (warm_cnt_r != '0) begin
        warm_cnt_r <= warm_cnt_r - 11'h001;
      end
    end
  end

  // ==========================================================================
  // access sequencer
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_r <= ACR_H_IDLE;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      is_rd_r <= 1'b0;
      rres_r <= 8'h00;
      pd_shadow_r <= `ACR_RST_PD;
    end else begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      unique case (st_r)
        ACR_H_IDLE: if (go) begin
          is_rd_r <= sw_wdata_i[`ACR_H_GO_RD];
          st_r <= ACR_H_HOLD;
        end
        ACR_H_HOLD: if (!is_rd_r && coeff_tgt && pd_shadow_r) begin
          st_r <= ACR_H_IDLE; // dropped
        end else if (may_go) begin
          wr_r <= !is_rd_r;
          rd_r <= is_rd_r;
          st_r <= ACR_H_STRB;
        end
        ACR_H_STRB: begin
          if (!is_rd_r && tgt_r == `ACR_OFS_OPTION) begin
            pd_shadow_r <= dat_r[`ACR_OPT_PD_BIT];
          end
          st_r <= is_rd_r ? ACR_H_CAPT : ACR_H_IDLE;
        end
        ACR_H_CAPT: begin
          rres_r <= bus.rdata;
          st_r <= ACR_H_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // software registers; refused flag: a new refusal wins over the clear
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tgt_r <= 4'h0;
      dat_r <= 8'h00;
      refused_r <= 1'b0;
      srd_r <= 8'h00;
    end else begin
      if (sw_wr_i && sw_addr_i == `ACR_H_ADDR && st_r == ACR_H_IDLE) begin
        tgt_r <= sw_wdata_i[3:0];
      end
      if (sw_wr_i && sw_addr_i == `ACR_H_DATA && st_r == ACR_H_IDLE) begin
        dat_r <= sw_wdata_i;
      end
      if (st_r == ACR_H_HOLD && !is_rd_r && coeff_tgt && pd_shadow_r) begin
        refused_r <= 1'b1;
      end else if (sw_wr_i && sw_addr_i == `ACR_H_STAT && sw_wdata_i[3]) begin
        refused_r <= 1'b0;
      end
      srd_r <= 8'h00;
      if (sw_rd_i) begin
        unique case (sw_addr_i)
          `ACR_H_ADDR: srd_r <= {4'h0, tgt_r};
          `ACR_H_DATA: srd_r <= dat_r;
          `ACR_H_STAT: srd_r <= {4'h0, refused_r, warm_cnt_r == '0,
                                 pwrup_cnt_r == '0, st_r != ACR_H_IDLE};
          `ACR_H_RDAT: srd_r <= rres_r;
          default: srd_r <= 8'h00;
        endcase
      end
    end
  end

  assign bus.addr = tgt_r;
  assign bus.wdata = dat_r;
  assign bus.wr = wr_r;
  assign bus.rd = rd_r;
  assign sw_rdata_o = srd_r;
endmodule

`default_nettype wire

// ==== acr_props.sv ====
/*
 * Holds: checker on the register port between host and device.
 * Assumes: one clock; calibration strobes come from the bench.
 */
`timescale 1ns/1ps
`default_nettype none

module acr_props #(
  parameter logic [6:0] PART_ID = 7'h00,
  parameter int PWRUP_CYC = 10,
  parameter int WARM_CYC = 20
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire acr_pkg::acr_addr_t addr,
  input wire acr_pkg::acr_byte_t wdata,
  input wire logic wr,
  input wire logic rd,
  input wire acr_pkg::acr_byte_t rdata,
  input wire logic cal_gain_vld_i,
  input wire logic cal_offs_vld_i
);
  import acr_pkg::*;
  logic pd_r;
  logic [47:0] sh_r;
  logic [5:0] vld_r;
  logic [10:0] pwr_r;
  logic [10:0] warm_r;
  logic [3:0] idx;
  logic [7:0] b;
  logic [7:0] exp_c;
  logic coeff;
  // ==========================================================================
  // shadow model
  assign idx = addr - 4'h8;
  assign coeff = (addr >= 4'h8) && (addr <= 4'hD);
  assign b = sh_r[8*idx[2:0] +: 8];
  // expected read byte with masked or sign-copied top bits
  always_comb begin
    exp_c = b;
    if (idx == 4'h2)
      exp_c = {6'h00, b[1:0]};
    if (idx == 4'h5)
      exp_c = {{4{b[3]}}, b[3:0]};
  end
  // power-down bit shadow
  always_ff @(posedge clk_i) begin
    if (!rstn_i)
      pd_r <= 1'b0;
    else if (wr && addr == 4'h0)
      pd_r <= wdata[0];
  end
  // coefficient bytes; a calibration load makes them unknown here
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sh_r <= 48'h0000_0000_0001;
      vld_r <= 6'h3F;
    end else begin
      if (wr && coeff) begin
        sh_r[8*idx[2:0] +: 8] <= wdata;
        vld_r[idx[2:0]] <= 1'b1;
      end
      if (cal_gain_vld_i)
        vld_r[2:0] <= 3'h0;
      if (cal_offs_vld_i)
        vld_r[5:3] <= 3'h0;
    end
  end
  // power-up wait counter
  always_ff @(posedge clk_i) begin
    if (!rstn_i)
      pwr_r <= 11'(PWRUP_CYC - 1);
    else if (pwr_r != 11'h000)
      pwr_r <= pwr_r - 11'h001;
  end
  // analog start-up wait counter
  always_ff @(posedge clk_i) begin
    if (!rstn_i)
      warm_r <= 11'h000;
    else if (wr && addr == 4'h0 && pd_r && !wdata[0])
      warm_r <= 11'(WARM_CYC - 1);
    else if (warm_r != 11'h000)
      warm_r <= warm_r - 11'h001;
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_part_id; rd && addr == 4'h0 |=> rdata[7:1] == PART_ID; endproperty
  a_part_id: assert property (p_part_id)
    else $error("part identifier wrong");
  property p_pd_read; rd && addr == 4'h0 |=> rdata[0] == $past(pd_r); endproperty
  a_pd_read: assert property (p_pd_read)
    else $error("power-down bit wrong");
  property p_gain_top; rd && addr == 4'hA |=> rdata[7:2] == 6'h00; endproperty
  a_gain_top: assert property (p_gain_top)
    else $error("gain top bits not zero");
  property p_offs_sign; rd && addr == 4'hD |=> rdata[7:4] == {4{rdata[3]}}; endproperty
  a_offs_sign: assert property (p_offs_sign)
    else $error("offset sign copies wrong");
  property p_gain_rd;
    rd && addr inside {4'h8, 4'h9, 4'hA} && vld_r[idx[2:0]] |=> rdata == $past(exp_c);
  endproperty
  a_gain_rd: assert property (p_gain_rd)
    else $error("gain byte wrong");
  property p_offs_rd;
    rd && addr inside {4'hB, 4'hC, 4'hD} && vld_r[idx[2:0]] |=> rdata == $past(exp_c);
  endproperty
  a_offs_rd: assert property (p_offs_rd)
    else $error("offset byte wrong");
  property p_host_pd; wr && coeff |-> !pd_r; endproperty
  a_host_pd: assert property (p_host_pd)
    else $error("coefficient written while powered down");
  property p_warm_hold; (wr || rd) |-> warm_r == 11'h000; endproperty
  a_warm_hold: assert property (p_warm_hold)
    else $error("access inside start-up wait");
  property p_pwrup_hold; (wr || rd) |-> pwr_r == 11'h000; endproperty
  a_pwrup_hold: assert property (p_pwrup_hold)
    else $error("access inside power-up wait");
  c_neg_offs: cover property (rd && addr == 4'hD ##1 rdata[3]);
  c_cal_load: cover property (cal_gain_vld_i && cal_offs_vld_i);
  c_warm_done: cover property (warm_r == 11'h001 ##1 warm_r == 11'h000);
endmodule

`default_nettype wire

// ==== adc_option_calib_coeff_regs_tb.sv ====
/*
 * Holds: bench driving software accesses through the host end.
 * Assumes: waits shortened to 10 and 20 cycles on both ends.
 */
`timescale 1ns/1ps
`default_nettype none

module adc_option_calib_coeff_regs_tb;
  import acr_pkg::*;
  localparam logic [6:0] PART_ID = 7'h15; // arbitrary identifier value
  localparam int PW = 10;
  localparam int WA = 20;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] mode_i = 4'h0;
  logic cal_gain_vld_i = 1'b0;
  logic [17:0] cal_gain_i = 18'h00000;
  logic cal_offs_vld_i = 1'b0;
  logic [19:0] cal_offs_i = 20'h00000;
  logic [2:0] sw_addr_i = 3'h0;
  logic [7:0] sw_wdata_i = 8'h00;
  logic sw_wr_i = 1'b0;
  logic sw_rd_i = 1'b0;
  logic [7:0] sw_rdata_o;
  logic [17:0] gain_o;
  logic [23:0] offset_o;
  logic analog_pd_o, analog_ready_o, op_ready_o, conv_allow_o;
  int errors = 0;
  int total_checks = 0;
  // ==========================================================================
  // clock and ends
  always #20 clk_i = ~clk_i;
  acr_if bus_if ();
  acr_dev #(.PART_ID(PART_ID), .PWRUP_CYC(PW), .WARM_CYC(WA)) acr_dev_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .bus(bus_if), .mode_i(mode_i),
    .cal_gain_vld_i(cal_gain_vld_i), .cal_gain_i(cal_gain_i),
    .cal_offs_vld_i(cal_offs_vld_i), .cal_offs_i(cal_offs_i), .gain_o(gain_o),
    .offset_o(offset_o), .analog_pd_o(analog_pd_o), .analog_ready_o(analog_ready_o),
    .op_ready_o(op_ready_o), .conv_allow_o(conv_allow_o));
  acr_host #(.PWRUP_CYC(PW), .WARM_CYC(WA)) acr_host_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .bus(bus_if), .sw_addr_i(sw_addr_i),
    .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o));
  acr_props #(.PART_ID(PART_ID), .PWRUP_CYC(PW), .WARM_CYC(WA)) acr_props_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr(bus_if.addr), .wdata(bus_if.wdata),
    .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
    .cal_gain_vld_i(cal_gain_vld_i), .cal_offs_vld_i(cal_offs_vld_i));
  // ==========================================================================
  // shared tasks
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic sw_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge clk_i);
    sw_wr_i <= 1'b0;
  endtask
  task automatic sw_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge clk_i);
    sw_rd_i <= 1'b0;
    #1 d = sw_rdata_o;
  endtask
  // one device access through the host, polling busy
  task automatic acc(input logic [3:0] a, input logic [7:0] d, input logic rdn,
                     output logic [7:0] st, output logic [7:0] r);
    int n;
    sw_wr(3'h0, {4'h0, a});
    sw_wr(3'h1, d);
    sw_wr(3'h2, rdn ? 8'h02 : 8'h01);
    st = 8'h01;
    for (n = 0; n < 200 && st[0] !== 1'b0; n++)
      sw_rd(3'h3, st);
    check(24'(st[0]), 24'h000000);
    sw_rd(3'h4, r);
  endtask
  task automatic wr_dev(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] st, r;
    acc(a, d, 1'b0, st, r);
  endtask
  task automatic rd_dev(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] st, r;
    acc(a, 8'h00, 1'b1, st, r);
    check({16'h0000, r}, {16'h0000, e});
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_powerup();
    logic [7:0] st;
    sw_wr(3'h2, 8'h02);
    sw_rd(3'h3, st);
    check({16'h0000, st}, 24'h000005);
    check(24'(op_ready_o), 24'h000000);
    repeat (PW - 6) @(posedge clk_i);
    #1 check(24'(op_ready_o), 24'h000000);
    repeat (4) @(posedge clk_i);
    #1 check(24'(op_ready_o), 24'h000001);
    sw_rd(3'h3, st);
    check({16'h0000, st}, 24'h000006);
    sw_rd(3'h4, st);
    check({16'h0000, st}, {16'h0000, PART_ID, 1'b0});
  endtask
  task automatic t_reset();
    rd_dev(4'h0, {PART_ID, 1'b0});
    for (int i = 0; i < 6; i++)
      rd_dev(4'h8 + 4'(i), (i == 0) ? 8'h01 : 8'h00);
  endtask
  task automatic t_coeff();
    logic [7:0] wd [6] = '{8'h5A, 8'hC3, 8'hFF, 8'h34, 8'h12, 8'h08};
    logic [7:0] rx [6] = '{8'h5A, 8'hC3, 8'h03, 8'h34, 8'h12, 8'hF8};
    for (int i = 0; i < 6; i++)
      wr_dev(4'h8 + 4'(i), wd[i]);
    for (int i = 0; i < 6; i++)
      rd_dev(4'h8 + 4'(i), rx[i]);
    check(24'(gain_o), 24'h03C35A);
    check(offset_o, 24'hF81234);
    wr_dev(4'hD, 8'h07);
    rd_dev(4'hD, 8'h07);
    check(offset_o, 24'h071234);
  endtask
  task automatic t_cal();
    @(posedge clk_i);
    cal_gain_i <= 18'h2ABCD;
    cal_offs_i <= 20'h80001;
    cal_gain_vld_i <= 1'b1;
    cal_offs_vld_i <= 1'b1;
    @(posedge clk_i);
    cal_gain_vld_i <= 1'b0;
    cal_offs_vld_i <= 1'b0;
    @(posedge clk_i);
    #1 check(24'(gain_o), 24'h02ABCD);
    check(offset_o, 24'hF80001);
    rd_dev(4'hA, 8'h02);
    rd_dev(4'hD, 8'hF8);
  endtask
  task automatic t_power();
    logic [7:0] st, r;
    wr_dev(4'h0, 8'hFF);
    repeat (2) @(posedge clk_i);
    #1 check(24'(analog_pd_o), 24'h000001);
    check(24'(conv_allow_o), 24'h000000);
    rd_dev(4'h0, {PART_ID, 1'b1});
    acc(4'h9, 8'h77, 1'b0, st, r);
    check(24'(st[3]), 24'h000001);
    sw_wr(3'h3, 8'h08);
    sw_rd(3'h3, st);
    check({16'h0000, st}, 24'h000006);
    rd_dev(4'h9, 8'hAB);
    @(posedge clk_i);
    mode_i <= 4'h2;
    repeat (3) @(posedge clk_i);
    #1 check(24'(analog_pd_o), 24'h000000);
    @(posedge clk_i);
    mode_i <= 4'h0;
    repeat (3) @(posedge clk_i);
    wr_dev(4'h0, 8'h00);
    check(24'(analog_ready_o), 24'h000000);
    check(24'(conv_allow_o), 24'h000000);
    wr_dev(4'hC, 8'h5E);
    rd_dev(4'hC, 8'h5E);
    check(24'(analog_ready_o), 24'h000001);
    check(24'(conv_allow_o), 24'h000001);
  endtask
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_powerup();
    t_reset();
    t_coeff();
    t_cal();
    t_power();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end
endmodule

`default_nettype wire
